// ===== bench/converter_load_current_meter_test.sv
// Self-checking bench of the load current meter
module converter_load_current_meter_test;
    timeunit 1ns;
    timeprecision 1ns;
    import load_meter_pkg::*;
    logic       core_clk    = 1'b0;
    logic       rst_n       = 1'b0;
    logic       regWrite, regRead, measBusy, measDone;
    logic [7:0] regAddr, regWdata, regRdata, rv;
    logic [8:0] senseFirst  = 9'h1ff; // Full scale code
    logic [8:0] senseSecond = 9'h0a5;
    int         n_errors    = 0;
    int         checks      = 0;
    reg_host host (.core_clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
    load_current_meter uut (.core_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .senseFirst, .senseSecond, .measBusy, .measDone);
    // 50 ns clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [8:0] exp);
        host.rd(a, rv);
        check({1'b0, rv}, exp);
    endtask
    // Bounded wait for the done pulse, counting cycles
    task automatic wait_done(output int n);
        n = 0;
        while (measDone !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 400) begin
                n_errors++;
                wrap_up();
            end
        end
    endtask
    // Second converter run, refused write, old result held
    task automatic second_run;
        int n;
        host.wr(ADDR_SELECT, 8'h01);
        check({8'h00, measBusy}, 9'h001);
        expect_reg(ADDR_SELECT, 9'h001);
        host.wr(ADDR_LOW, 8'h33);
        expect_reg(ADDR_LOW, 9'h000);
        wait_done(n);
        expect_reg(ADDR_HIGH, 9'h000);
        expect_reg(ADDR_LOW, 9'h0a5);
    endtask
    // Restart mid-run on first converter, reserved bits set
    task automatic restart_run;
        int n;
        host.wr(ADDR_SELECT, 8'h01);
        repeat (50) @(negedge core_clk);
        host.wr(ADDR_SELECT, 8'hfe);
        expect_reg(ADDR_SELECT, 9'h0fe);
        expect_reg(ADDR_LOW, 9'h0a5);
        wait_done(n);
        check({8'h00, (n >= MEAS_CYCLES - 4) && (n <= MEAS_CYCLES + 4)}, 9'h001);
        expect_reg(ADDR_HIGH, 9'h001);
        expect_reg(ADDR_LOW, 9'h0ff);
    endtask
    // Reset, then scenarios in turn
    initial begin
        repeat (4) @(negedge core_clk);
        rst_n <= 1'b1;
        expect_reg(ADDR_SELECT, 9'h000);
        expect_reg(ADDR_HIGH, 9'h000);
        expect_reg(8'h27, 9'h000);
        second_run();
        restart_run();
        wrap_up();
    end
endmodule // converter_load_current_meter_test
bind load_current_meter load_current_meter_sva chk (.core_clk, .rst_n, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .measBusy, .measDone);

// ===== bench/load_current_meter_sva.sv
// Port timing checker of the load current meter
module load_current_meter_sva
    import load_meter_pkg::*;
(
    // Clock, reset, register port and status
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       measBusy,
    input wire logic       measDone
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_write_starts_run: assert property (regWrite && regAddr == ADDR_SELECT |=> measBusy)
        else $error("no busy after select write");
    a_run_min_length: assert property ($rose(measBusy) |-> measBusy[*8])
        else $error("run ended too early");
    a_done_ends_run: assert property (measDone |-> $past(measBusy) && (!measBusy
        || $past(regWrite && regAddr == ADDR_SELECT)))
        else $error("done without run end");
    a_done_single_pulse: assert property (measDone |=> !measDone)
        else $error("done longer than a cycle");
    a_done_after_window: assert property (measDone |-> $past(measBusy, 200))
        else $error("done before averaging window");
    a_idle_read_zero: assert property (!regRead |=> regRdata == READ_ZERO)
        else $error("read data not zero when idle");
    a_high_upper_zero: assert property (regRead && regAddr == ADDR_HIGH |=> regRdata[7:1] == 7'h00)
        else $error("upper result bits not zero");
    a_select_read_back: assert property ((regWrite && regAddr == ADDR_SELECT)
        ##1 !(regWrite && regAddr == ADDR_SELECT) ##1 (regRead && regAddr == ADDR_SELECT)
        |=> regRdata == $past(regWdata, 3))
        else $error("select read back differs");
endmodule // load_current_meter_sva

// ===== bench/reg_host.sv
// Host model issuing single register transfers
module reg_host (
    // Register port
    input  wire logic       core_clk,
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWdata,
    input  wire logic [7:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus from time zero
    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end
    // One write, bit 0 of select data picks the converter
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(negedge core_clk);
        regWrite <= 1'b0;
    endtask
    // One read, data taken in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(negedge core_clk);
        regRead <= 1'b0;
        d = regRdata;
    endtask
endmodule // reg_host

// ===== core/load_averager.sv
// Averager that integrates sampled current codes over a fixed window
module load_averager
    import load_meter_pkg::*;
(
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Synchronised samples from both converters
    input  wire logic [ResultWidth-1:0]  sampleFirst,
    input  wire logic [ResultWidth-1:0]  sampleSecond,
    // Request and result
    meas_if.avg                          meas
);
    localparam logic [CountWidth-1:0] LAST = CountWidth'(MEAS_CYCLES - 1); // Final count

    logic                    busy;       // Window in progress
    logic                    next_busy;
    logic                    sel;        // Latched converter
    logic                    next_sel;
    logic [CountWidth-1:0]   cnt;        // Samples taken
    logic [CountWidth-1:0]   next_cnt;
    logic [AccWidth-1:0]     acc;        // Running sum
    logic [AccWidth-1:0]     next_acc;
    logic                    done;       // Completion pulse
    logic                    next_done;
    logic [ResultWidth-1:0]  avgOut;     // Held average
    logic [ResultWidth-1:0]  next_avgOut;
    logic [ResultWidth-1:0]  sample;     // Sample of chosen converter
    logic [AccWidth-1:0]     sum;        // Sum including this sample

    // Next state: restart on any start, average over window
    always_comb begin
        sample      = sel ? sampleSecond : sampleFirst;
        sum         = acc + AccWidth'(sample);
        next_busy   = busy;
        next_sel    = sel;
        next_cnt    = cnt;
        next_acc    = acc;
        next_done   = 1'b0;
        next_avgOut = avgOut;
        if (meas.start) begin                                   // RL1
            next_busy = 1'b1;
            next_sel  = meas.convSel;                           // RL2
            next_cnt  = '0;
            next_acc  = '0;
        end else if (busy) begin
            next_acc = sum;
            next_cnt = cnt + CountWidth'(1);
            if (cnt == LAST) begin
                // Unsigned count of 20 mA steps, mean never above full scale
                next_avgOut = ResultWidth'(sum / AccWidth'(MEAS_CYCLES)); // RL5
                next_done   = 1'b1;
                next_busy   = 1'b0;
            end
        end
    end

    // Register stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy   <= 1'b0;
            sel    <= 1'b0;
            cnt    <= '0;
            acc    <= '0;
            done   <= 1'b0;
            avgOut <= RESULT_RESET;
        end else begin
            busy   <= next_busy;
            sel    <= next_sel;
            cnt    <= next_cnt;
            acc    <= next_acc;
            done   <= next_done;
            avgOut <= next_avgOut;
        end
    end

    assign meas.done    = done;
    assign meas.average = avgOut;
endmodule : load_averager

// ===== core/load_current_meter.sv
// Load current meter register block for two step-down converters
// Behaviour
// RL1: Any select register write starts measurement.
// RL2: Bit 0 chooses first or second converter.
// RL3: High register bit 0 holds result bit 8.
// RL4: Low register holds result bits 7:0.
// RL5: Result counts unsigned 20 mA steps.
// RL6: Old result held until both halves update.
//
// Operation
// Select write latches all eight data bits
// Same write raises a one-cycle start pulse
// Latched bit 0 steers the averager
// Any data value starts a run, reserved bits too
// Averager sums one synchronised code per clock
// Window length set by the package constants
// Averager returns the floor of the mean
// Done pulse from the averager carries the result
//
// Publishing
// All nine result bits held in one register
// High and low halves always from one run
// Both halves load on the same clock edge
// A completion between two host reads can split a pair
// Hosts wanting a matched pair read after the done pulse
//
// Restart
// Select write during a run discards that run
// Averager clears its sum on the start pulse
// Done meeting a start pulse belongs to the old run
// Such a done is dropped, old result stays
// Done plus write in one cycle: result loads, new run starts
//
// Status
// measBusy is a registered copy of the next state
// measBusy rises one cycle after the select write
// measDone pulses once on the result load edge
// Both halves readable from the cycle after measDone
//
// Read port
// Read data registered, stands for one cycle
// Zero without a read strobe
// Zero for unmapped addresses
// Writes to the result registers are ignored
//
// Reset
// Asynchronous, active low
// Select latch and result clear to zero
// Read port, busy and done low during reset
// First host access allowed one edge after release
//
// Limitations
// Sense codes cross as nine parallel bits
// Plain two-flop synchroniser per bit
// Front end must hold each code for several clocks
// Otherwise a mixed word can enter the sum
// No saturation needed: the mean never exceeds full scale
module load_current_meter
    import load_meter_pkg::*;
(
    // Clock and reset
    input  wire logic                                    core_clk,
    input  wire logic                                    rst_n,
    // Register port from the serial interface
    input  wire logic                                    regWrite,
    input  wire logic                                    regRead,
    input  wire logic [load_meter_pkg::AddrWidth-1:0]    regAddr,
    input  wire logic [load_meter_pkg::DataWidth-1:0]    regWdata,
    output logic      [load_meter_pkg::DataWidth-1:0]    regRdata,
    // Current sense codes from the analog front end
    input  wire logic [load_meter_pkg::ResultWidth-1:0]  senseFirst,
    input  wire logic [load_meter_pkg::ResultWidth-1:0]  senseSecond,
    // Status
    output logic                                         measBusy,
    output logic                                         measDone
);
    import load_meter_pkg::*;

    // One-hot control states
    typedef enum logic [1:0] {
        IDLE    = 2'b01,                              // No measurement running
        MEASURE = 2'b10                               // Averaging in progress
    } state_t;

    // Control state
    state_t                  state;                  // Control state
    state_t                  next_state;             // Next control state

    // Select latch and published result
    logic [DataWidth-1:0]    selectReg;              // measure_select_start
    logic [DataWidth-1:0]    next_selectReg;         // Next select latch
    logic [ResultWidth-1:0]  result;                 // Published result
    logic [ResultWidth-1:0]  next_result;            // Next published result

    // Next values of registered outputs
    logic [DataWidth-1:0]    next_regRdata;          // Next read data
    logic                    next_measBusy;          // Next busy level
    logic                    next_measDone;          // Next done pulse

    // Start request towards the averager
    logic                    startPulse;             // Start request to averager
    logic                    next_startPulse;        // Next start request

    // Synchroniser stages for both sense codes
    logic [ResultWidth-1:0]  firstMeta;              // Sense sync stage one
    logic [ResultWidth-1:0]  secondMeta;
    logic [ResultWidth-1:0]  firstSync;              // Sense sync stage two
    logic [ResultWidth-1:0]  secondSync;

    // Start and result travel in one bundle
    meas_if meas ();                                 // Link to averager

    // Decode a write to the select register
    // Shared by the start decode and the restart test
    function automatic logic isSelWrite(input logic wr, input logic [AddrWidth-1:0] a);
        return wr && (a == ADDR_SELECT);
    endfunction

    // Two-flop synchroniser for analog front end codes
    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            firstMeta  <= RESULT_RESET;
            secondMeta <= RESULT_RESET;
            firstSync  <= RESULT_RESET;
            secondSync <= RESULT_RESET;
        end else begin
            firstMeta  <= senseFirst;
            secondMeta <= senseSecond;
            firstSync  <= firstMeta;
            secondSync <= secondMeta;
        end
    end

    // Next state of control, registers and read data
    always_comb begin
        // Defaults: hold state, no pulses, read port idle
        next_state      = state;
        next_selectReg  = selectReg;
        next_result     = result;
        next_startPulse = 1'b0;
        next_measDone   = 1'b0;
        next_regRdata   = READ_ZERO;
        // Any write to the select register restarts, value irrelevant
        if (isSelWrite(regWrite, regAddr)) begin
            // Latch all bits, reserved ones included
            next_selectReg  = regWdata;
            next_startPulse = 1'b1;                   // RL1
            next_state      = MEASURE;
        end
        // Completion handling per control state
        case (state)
            IDLE: begin
                // Nothing to finish
            end
            MEASURE: begin
                // Completion publishes both halves at once; a start in the
                // same cycle is the newer request and keeps us measuring
                if (meas.done && !startPulse) begin
                    next_result   = meas.average;     // RL6
                    next_measDone = 1'b1;
                    // A same-cycle write keeps the block measuring
                    if (!isSelWrite(regWrite, regAddr)) begin
                        next_state = IDLE;
                    end
                end
            end
            // Illegal code falls back to idle
            default: begin
                next_state = IDLE;
            end
        endcase
        // Busy level mirrors the next state
        next_measBusy = (next_state == MEASURE);
        // Read mux
        if (regRead) begin
            case (regAddr)
                ADDR_SELECT: next_regRdata = selectReg;
                ADDR_HIGH:   next_regRdata = {7'h00, result[RES_MSB]};        // RL3
                ADDR_LOW:    next_regRdata = result[DataWidth-1:0];           // RL4
                default:     next_regRdata = READ_ZERO;
            endcase
        end
    end

    // Register stage
    // Reset clears outputs so the read port idles at zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= IDLE;
            selectReg  <= SELECT_RESET;
            result     <= RESULT_RESET;
            startPulse <= 1'b0;
            regRdata   <= READ_ZERO;
            measBusy   <= 1'b0;
            measDone   <= 1'b0;
        end else begin
            state      <= next_state;
            selectReg  <= next_selectReg;
            result     <= next_result;
            startPulse <= next_startPulse;
            regRdata   <= next_regRdata;
            measBusy   <= next_measBusy;
            measDone   <= next_measDone;
        end
    end

    // Request fields towards the averager
    assign meas.start   = startPulse;
    assign meas.convSel = selectReg[SEL_BIT];         // RL2

    // Averager of the chosen converter
    // Sense codes enter the averager already synchronised
    load_averager u_averager (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .sampleFirst  (firstSync),
        .sampleSecond (secondSync),
        .meas         (meas)
    );
endmodule : load_current_meter

// ===== core/load_meter_pkg.sv
// Package with register map, field layout and timing constants of the load current meter
package load_meter_pkg;
    localparam int          AddrWidth       = 8;                 // Register address width
    localparam int          DataWidth       = 8;                 // Register data width
    localparam int          ResultWidth     = 9;                 // Result width in 20 mA steps
    localparam logic [7:0]  ADDR_SELECT     = 8'h24;             // measure_select_start
    localparam logic [7:0]  ADDR_HIGH       = 8'h25;             // load_current_high
    localparam logic [7:0]  ADDR_LOW        = 8'h26;             // load_current_low
    localparam int          SEL_BIT         = 0;                 // Converter select bit
    localparam int          RES_MSB         = 8;                 // Result MSB position
    localparam logic [7:0]  SELECT_RESET    = 8'h00;             // Select register reset
    localparam logic [8:0]  RESULT_RESET    = 9'h000;            // Result reset value
    localparam logic [7:0]  READ_ZERO       = 8'h00;             // Unmapped and reserved reads
    localparam int          STEP_MA         = 20;                // Milliamps per result LSB
    localparam int          FULL_SCALE_MA   = 10220;             // Largest reportable current
    localparam int          MEAS_TIME_NS    = 10000;             // Averaging window length
    localparam int          CLK_PERIOD_NS   = 50;                // core_clk period
    localparam int          MEAS_CYCLES     = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CountWidth      = 16;                // Averaging sample counter width
    localparam int          AccWidth        = ResultWidth + CountWidth; // Accumulator width
    localparam logic [1:0]  CONV_FIRST      = 2'h1;              // first_converter one-hot
    localparam logic [1:0]  CONV_SECOND     = 2'h2;              // second_converter one-hot
endpackage : load_meter_pkg

// ===== core/meas_if.sv
// Interface carrying the start request and averaged result between meter and averager
interface meas_if;
    import load_meter_pkg::*;
    logic                    start;        // One-cycle start pulse
    logic                    convSel;      // 0 first_converter, 1 second_converter
    logic                    done;         // One-cycle completion pulse
    logic [ResultWidth-1:0]  average;      // Averaged result, valid with done
    modport ctrl (output start, output convSel, input done, input average);
    modport avg  (input start, input convSel, output done, output average);
endinterface : meas_if
